/* File: hdl/adcp_pkg.sv */
// Purpose: shared constants for the converter two-wire register port
// Assumes: 100 MHz REF_CLK on both ends
// Notes: strap codes map the address select pin to the low address bits
package adcp_pkg;
    typedef logic [15:0] adcp_word_t;
    typedef logic [6:0] adcp_addr_t;
    // bus address family; the strap picks the two low bits
    localparam adcp_addr_t ADCP_ADDR_BASE = 7'h48;
    localparam logic [1:0] ADCP_STRAP_GND = 2'h0;
    localparam logic [1:0] ADCP_STRAP_VDD = 2'h1;
    localparam logic [1:0] ADCP_STRAP_SDA = 2'h2;
    localparam logic [1:0] ADCP_STRAP_SCL = 2'h3;
    // register pointer codes
    localparam logic [1:0] ADCP_PTR_CONV = 2'h0;
    localparam logic [1:0] ADCP_PTR_CFG = 2'h1;
    localparam logic [1:0] ADCP_PTR_LOW = 2'h2;
    localparam logic [1:0] ADCP_PTR_HIGH = 2'h3;
    // reset values and the read-only low nibble of the limit registers
    localparam adcp_word_t ADCP_CFG_RST = 16'h0000;
    localparam adcp_word_t ADCP_LOW_RST = 16'h8000;
    localparam adcp_word_t ADCP_HIGH_RST = 16'h7FFF;
    localparam adcp_word_t ADCP_LIMIT_RO_MASK = 16'h000F;
    // frame shape
    localparam logic [3:0] ADCP_BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] ADCP_LAST_WR_IDX = 3'h3;
    // timing
    localparam int ADCP_CLK_NS = 10;
    localparam int ADCP_SDA_HOLD_NS = 100;
    localparam int ADCP_SDA_HOLD_CYC = (ADCP_SDA_HOLD_NS + ADCP_CLK_NS - 1) / ADCP_CLK_NS;
    localparam int ADCP_SCL_QTR_NS = 625;
    localparam int ADCP_SCL_QTR_CYC = (ADCP_SCL_QTR_NS + ADCP_CLK_NS - 1) / ADCP_CLK_NS;
    localparam logic [7:0] ADCP_QTR_LAST = 8'(ADCP_SCL_QTR_CYC - 1);
endpackage

/* File: hdl/adcp_if.sv */
// Purpose: open-drain two-wire bus between controller and target
// Assumes: pull-ups hold a released line high
// Notes: each line is low when any enabled driver pulls it low
`timescale 1ns/1ps
interface adcp_if;
    logic host_scl_out;
    logic host_scl_oe_n;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic target_sda_out;
    logic target_sda_oe_n;
    logic scl;
    logic sda;
    // wired-and resolution of both lines
    assign scl = host_scl_oe_n ? 1'b1 : host_scl_out;
    assign sda = (host_sda_oe_n ? 1'b1 : host_sda_out) & (target_sda_oe_n ? 1'b1 : target_sda_out);
    modport target (input scl, input sda, output target_sda_out, output target_sda_oe_n);
    modport controller (input scl, input sda, output host_scl_out, output host_scl_oe_n,
                        output host_sda_out, output host_sda_oe_n);
endinterface

/* File: hdl/adcp_target.sv */
// Purpose: target end of the converter register port
// Assumes: SCL and SDA are synchronous to REF_CLK
// Notes: the word of the register selected by the pointer is latched at the start of each read
//
// How it works
// - strap pin picks one of four addresses
// - controller holds SDA steady at least 100 ns after fall
// - controller clocks SCL; target never drives it
// - first byte: 7-bit address plus direction
// - second write byte loads the pointer
// - bytes three, four write selected register, MSB first
// - frames open with START, close with STOP
// - pointer 1 is config, 0 is conversion
// - pointer-only write just moves the pointer
// - reads return MSB then LSB
// - target never stretches the clock
// - pointer 2 low limit, 3 high limit
`timescale 1ns/1ps
module adcp_target (
    input wire logic REF_CLK,
    input wire logic RST_B,
    adcp_if.target BUS,
    input wire logic [1:0] ADDR_SEL,
    input wire adcp_pkg::adcp_word_t CONV_DATA,
    output adcp_pkg::adcp_word_t CFG_REG,
    output adcp_pkg::adcp_word_t LOW_LIMIT,
    output adcp_pkg::adcp_word_t HIGH_LIMIT,
    output logic [1:0] PTR,
    output logic SELECTED
);
    import adcp_pkg::*;

    typedef enum logic [2:0] {T_IDLE, T_RECV, T_ACK, T_SEND, T_MACK, T_SKIP} adcp_tstate_e;

    adcp_tstate_e state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [7:0] shreg;
    logic [7:0] tx_sh;
    logic [7:0] data_hi;
    logic rw;
    logic tx_lsb;
    logic sda_drive_n;
    adcp_word_t rd_latch;

    // register selected by a pointer code
    function automatic adcp_word_t reg_read(input logic [1:0] p, input adcp_word_t conv,
                                            input adcp_word_t cfg, input adcp_word_t lo,
                                            input adcp_word_t hi);
        adcp_word_t r;
        r = conv;
        unique case (p)
            ADCP_PTR_CONV: r = conv;
            ADCP_PTR_CFG: r = cfg;
            ADCP_PTR_LOW: r = lo;
            ADCP_PTR_HIGH: r = hi;
        endcase
        return r;
    endfunction

    // bus event decode from the previous line levels
    wire scl_rise = BUS.scl & ~scl_q;
    wire scl_fall = ~BUS.scl & scl_q;
    wire start_cond = scl_q & BUS.scl & sda_q & ~BUS.sda;
    wire stop_cond = scl_q & BUS.scl & ~sda_q & BUS.sda;
    wire byte_done = scl_fall & (bit_cnt == ADCP_BITS_PER_BYTE);
    wire adcp_addr_t my_addr = ADCP_ADDR_BASE | {5'h00, ADDR_SEL};
    wire addr_hit = (shreg[7:1] == my_addr);
    wire adcp_word_t rd_word = reg_read(PTR, CONV_DATA, CFG_REG, LOW_LIMIT, HIGH_LIMIT);
    wire in_recv_done = (state == T_RECV) & byte_done;
    wire wr_strobe = in_recv_done & (byte_idx == ADCP_LAST_WR_IDX);
    wire ptr_strobe = in_recv_done & (byte_idx == 3'h1);
    wire adcp_word_t wr_word = {data_hi, shreg};
    wire [7:0] next_tx = tx_lsb ? rd_latch[7:0] : rd_latch[15:8];

    // line history for edge and condition detection
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= BUS.scl;
            sda_q <= BUS.sda;
        end
    end

    // only SDA is ever pulled; SCL has no driver here and is never held
    assign BUS.target_sda_out = 1'b0;
    assign BUS.target_sda_oe_n = sda_drive_n;

    // frame sequencer
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= T_IDLE;
            bit_cnt <= 4'h0;
            byte_idx <= 3'h0;
            shreg <= 8'h00;
            tx_sh <= 8'h00;
            data_hi <= 8'h00;
            rw <= 1'b0;
            tx_lsb <= 1'b0;
            sda_drive_n <= 1'b1;
            rd_latch <= 16'h0000;
            SELECTED <= 1'b0;
        end else if (start_cond) begin
            state <= T_RECV;
            bit_cnt <= 4'h0;
            byte_idx <= 3'h0;
            sda_drive_n <= 1'b1;
            SELECTED <= 1'b0;
        end else if (stop_cond) begin
            state <= T_IDLE;
            sda_drive_n <= 1'b1;
            SELECTED <= 1'b0;
        end else begin
            unique case (state)
                T_IDLE, T_SKIP: begin
                    sda_drive_n <= 1'b1;
                end
                T_RECV: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], BUS.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        byte_idx <= byte_idx + 3'h1;
                        if (byte_idx == 3'h0) begin
                            if (addr_hit) begin
                                rw <= shreg[0];
                                SELECTED <= 1'b1;
                                sda_drive_n <= 1'b0;
                                state <= T_ACK;
                            end else begin
                                state <= T_SKIP;
                            end
                        end else if (byte_idx <= ADCP_LAST_WR_IDX) begin
                            if (byte_idx == 3'h2) begin
                                data_hi <= shreg;
                            end
                            sda_drive_n <= 1'b0;
                            state <= T_ACK;
                        end else begin
                            state <= T_SKIP;
                        end
                    end
                end
                T_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            rd_latch <= rd_word;
                            tx_sh <= rd_word[15:8];
                            sda_drive_n <= rd_word[15];
                            tx_lsb <= 1'b1;
                            bit_cnt <= 4'h1;
                            state <= T_SEND;
                        end else begin
                            sda_drive_n <= 1'b1;
                            state <= T_RECV;
                        end
                    end
                end
                T_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt == ADCP_BITS_PER_BYTE) begin
                            sda_drive_n <= 1'b1;
                            state <= T_MACK;
                        end else begin
                            sda_drive_n <= tx_sh[6];
                            tx_sh <= {tx_sh[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                T_MACK: begin
                    if (scl_rise && BUS.sda) begin
                        state <= T_SKIP;
                    end else if (scl_fall) begin
                        tx_sh <= next_tx;
                        sda_drive_n <= next_tx[7];
                        tx_lsb <= ~tx_lsb;
                        bit_cnt <= 4'h1;
                        state <= T_SEND;
                    end
                end
                default: begin
                    state <= T_SKIP;
                end
            endcase
        end
    end

    // pointer and register stores; the conversion register is read-only
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PTR <= ADCP_PTR_CONV;
            CFG_REG <= ADCP_CFG_RST;
            LOW_LIMIT <= ADCP_LOW_RST;
            HIGH_LIMIT <= ADCP_HIGH_RST;
        end else if (ptr_strobe) begin
            PTR <= shreg[1:0];
        end else if (wr_strobe) begin
            unique case (PTR)
                ADCP_PTR_CONV: CFG_REG <= CFG_REG;
                ADCP_PTR_CFG: CFG_REG <= wr_word;
                ADCP_PTR_LOW: LOW_LIMIT <= wr_word & ~ADCP_LIMIT_RO_MASK;
                ADCP_PTR_HIGH: HIGH_LIMIT <= wr_word | ADCP_LIMIT_RO_MASK;
            endcase
        end
    end
endmodule

/* File: hdl/adcp_controller.sv */
// Purpose: controller end that runs write and read frames on the bus
// Assumes: GO is taken only while BUSY is low
// Notes: each bit is four quarter periods of SCL
`timescale 1ns/1ps
module adcp_controller (
    input wire logic REF_CLK,
    input wire logic RST_B,
    adcp_if.controller BUS,
    input wire logic GO,
    input wire logic READ,
    input wire adcp_pkg::adcp_addr_t DEV_ADDR,
    input wire logic [1:0] WR_COUNT,
    input wire logic [23:0] WR_DATA,
    output logic BUSY,
    output logic DONE,
    output logic NACK,
    output adcp_pkg::adcp_word_t RD_DATA
);
    import adcp_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} adcp_hstate_e;

    adcp_hstate_e state;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [1:0] byte_cnt;
    logic [1:0] last_byte;
    logic [7:0] tx;
    logic [7:0] rx;
    logic rd;
    logic ack_bad;
    logic [23:0] wdata;

    // quarter-period enable, bit phase decode
    wire tick = BUSY & (qcnt == ADCP_QTR_LAST);
    wire sending = (byte_cnt == 2'h0) | ~rd;
    wire in_ack = (bit_idx == ADCP_BITS_PER_BYTE);
    wire at_last = (byte_cnt == last_byte);
    wire [7:0] wr_byte = (byte_cnt == 2'h0) ? wdata[23:16] :
                         (byte_cnt == 2'h1) ? wdata[15:8] : wdata[7:0];

    assign BUS.host_scl_out = 1'b0;
    assign BUS.host_sda_out = 1'b0;

    // quarter-period divider
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            qcnt <= 8'h00;
        end else begin
            qcnt <= (tick || !BUSY) ? 8'h00 : qcnt + 8'h01;
        end
    end

    // frame engine; SDA changes one quarter after SCL falls
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= H_IDLE;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            byte_cnt <= 2'h0;
            last_byte <= 2'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            rd <= 1'b0;
            ack_bad <= 1'b0;
            wdata <= 24'h000000;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            NACK <= 1'b0;
            RD_DATA <= 16'h0000;
            BUS.host_scl_oe_n <= 1'b1;
            BUS.host_sda_oe_n <= 1'b1;
        end else begin
            DONE <= 1'b0;
            if (state == H_IDLE) begin
                if (GO) begin
                    BUSY <= 1'b1;
                    NACK <= 1'b0;
                    rd <= READ;
                    tx <= {DEV_ADDR, READ};
                    wdata <= WR_DATA;
                    last_byte <= READ ? 2'h2 : WR_COUNT;
                    phase <= 2'h0;
                    state <= H_START;
                end
            end else if (tick) begin
                phase <= phase + 2'h1;
                unique case (state)
                    H_START: begin
                        if (phase == 2'h0) begin
                            BUS.host_sda_oe_n <= 1'b0;
                        end else if (phase == 2'h1) begin
                            BUS.host_scl_oe_n <= 1'b0;
                            bit_idx <= 4'h0;
                            byte_cnt <= 2'h0;
                            phase <= 2'h0;
                            state <= H_BIT;
                        end
                    end
                    H_BIT: begin
                        unique case (phase)
                            2'h0: begin
                                if (!in_ack) begin
                                    BUS.host_sda_oe_n <= sending ? tx[7] : 1'b1;
                                end else begin
                                    BUS.host_sda_oe_n <= sending | at_last;
                                end
                            end
                            2'h1: BUS.host_scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (!in_ack) begin
                                    rx <= {rx[6:0], BUS.sda};
                                end else begin
                                    ack_bad <= sending & BUS.sda;
                                end
                            end
                            2'h3: begin
                                BUS.host_scl_oe_n <= 1'b0;
                                if (!in_ack) begin
                                    bit_idx <= bit_idx + 4'h1;
                                    tx <= {tx[6:0], 1'b0};
                                end else begin
                                    bit_idx <= 4'h0;
                                    if (!sending && byte_cnt == 2'h1) begin
                                        RD_DATA[15:8] <= rx;
                                    end else if (!sending) begin
                                        RD_DATA[7:0] <= rx;
                                    end
                                    if (ack_bad || at_last) begin
                                        NACK <= ack_bad;
                                        state <= H_STOP;
                                    end else begin
                                        tx <= wr_byte;
                                        byte_cnt <= byte_cnt + 2'h1;
                                    end
                                end
                            end
                        endcase
                    end
                    H_STOP: begin
                        unique case (phase)
                            2'h0: BUS.host_sda_oe_n <= 1'b0;
                            2'h1: BUS.host_scl_oe_n <= 1'b1;
                            2'h2: BUS.host_sda_oe_n <= 1'b1;
                            2'h3: begin
                                BUSY <= 1'b0;
                                DONE <= 1'b1;
                                state <= H_IDLE;
                            end
                        endcase
                    end
                    default: state <= H_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: verification/adcp_asserts.sv */
// Purpose: bus checks on the two-wire link between controller and target
// Assumes: one REF_CLK domain, lines sampled on its rising edge
// Notes: frame position is tracked from the resolved scl and sda levels
`timescale 1ns/1ps
module adcp_asserts
    import adcp_pkg::*;
#(
    parameter int FRAME_MAX = 10000
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic host_scl_out,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_out,
    input wire logic host_sda_oe_n,
    input wire logic target_sda_out,
    input wire logic target_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic in_frame;
    logic rd_frame;
    logic [3:0] bit_idx;
    logic [1:0] byte_idx;
    logic [7:0] low_cnt;
    int frame_cnt;
    // line events decoded from the previous sample
    wire start_ev = scl & scl_q & sda_q & ~sda;
    wire stop_ev = scl & scl_q & ~sda_q & sda;
    wire bit_rise = scl & ~scl_q & in_frame;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // frame position: bit in byte, byte in frame, direction bit
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            in_frame <= 1'b0;
            rd_frame <= 1'b0;
            bit_idx <= 4'h0;
            byte_idx <= 2'h0;
            low_cnt <= 8'h00;
            frame_cnt <= 0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            in_frame <= start_ev | (in_frame & ~stop_ev);
            frame_cnt <= in_frame ? frame_cnt + 1 : 0;
            low_cnt <= scl ? 8'h00 : (low_cnt == 8'hFF ? low_cnt : low_cnt + 8'h01);
            if (start_ev) begin
                bit_idx <= 4'h0;
                byte_idx <= 2'h0;
                rd_frame <= 1'b0;
            end else if (bit_rise) begin
                bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                if (bit_idx == 4'h8 && byte_idx != 2'h3)
                    byte_idx <= byte_idx + 2'h1;
                if (bit_idx == 4'h7 && byte_idx == 2'h0)
                    rd_frame <= sda;
            end
        end
    end
    property p_scl_idle_high;
        !in_frame |-> scl;
    endproperty
    a_scl_idle_high: assert property (p_scl_idle_high)
        else $error("scl low outside a frame");
    property p_scl_high_width;
        $rose(scl) |-> scl [*8];
    endproperty
    a_scl_high_width: assert property (p_scl_high_width)
        else $error("scl high phase too short");
    property p_sda_hold;
        !scl && $changed(host_sda_oe_n) |-> low_cnt >= ADCP_SDA_HOLD_CYC;
    endproperty
    a_sda_hold: assert property (p_sda_hold)
        else $error("controller moved sda too soon after scl fell");
    property p_start_idle;
        start_ev |-> !in_frame;
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("start inside a frame");
    property p_stop_on_boundary;
        stop_ev |-> in_frame && bit_idx == 4'h1;
    endproperty
    a_stop_on_boundary: assert property (p_stop_on_boundary)
        else $error("stop not after a whole byte");
    property p_frame_bounded;
        in_frame |-> frame_cnt < FRAME_MAX;
    endproperty
    a_frame_bounded: assert property (p_frame_bounded)
        else $error("frame never closed");
    property p_target_slot;
        bit_rise && !target_sda_oe_n |->
            ((rd_frame && byte_idx != 2'h0) ? bit_idx != 4'h8 : bit_idx == 4'h8);
    endproperty
    a_target_slot: assert property (p_target_slot)
        else $error("target pulled sda outside its slot");
    property p_target_moves_low;
        $changed(target_sda_oe_n) |-> !scl;
    endproperty
    a_target_moves_low: assert property (p_target_moves_low)
        else $error("target moved sda while scl high");
    property p_target_quiet;
        !in_frame |-> target_sda_oe_n;
    endproperty
    a_target_quiet: assert property (p_target_quiet)
        else $error("target drives sda between frames");
    // an enabled driver may only pull its line low, never push it high
    property p_open_drain;
        !((!host_scl_oe_n && host_scl_out) || (!host_sda_oe_n && host_sda_out) ||
            (!target_sda_oe_n && target_sda_out));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("a driver pushed a line high");
endmodule

/* File: verification/adc_i2c_register_access_port_tb.sv */
// Purpose: drives frames through the controller end and checks the target end
// Assumes: controller and target joined by one bus interface
// Notes: expectations come from a shadow copy of the target registers
`timescale 1ns/1ps
module adc_i2c_register_access_port_tb;
    import adcp_pkg::*;
    typedef struct packed {
        logic rd;
        logic nack;
        logic sel;
        adcp_word_t data;
        adcp_word_t cfg;
        adcp_word_t low;
        adcp_word_t high;
        logic [1:0] ptr;
    } adcp_exp_s;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic go = 1'b0;
    logic read = 1'b0;
    adcp_addr_t dev_addr = ADCP_ADDR_BASE;
    logic [1:0] wr_count = 2'h0;
    logic [23:0] wr_data = 24'h000000;
    logic [1:0] addr_sel = ADCP_STRAP_GND;
    adcp_word_t conv_data = 16'h0000;
    adcp_word_t cfg_reg, low_limit, high_limit, rd_data;
    logic [1:0] ptr;
    logic selected, busy, done, nack, sel_seen;
    adcp_exp_s exp_q[$];
    adcp_exp_s want;
    adcp_exp_s got;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    adcp_if adcp_if_i();
    adcp_target adcp_target_i (.REF_CLK(ref_clk), .RST_B(rst_b), .BUS(adcp_if_i),
        .ADDR_SEL(addr_sel), .CONV_DATA(conv_data), .CFG_REG(cfg_reg), .LOW_LIMIT(low_limit),
        .HIGH_LIMIT(high_limit), .PTR(ptr), .SELECTED(selected));
    adcp_controller adcp_controller_i (.REF_CLK(ref_clk), .RST_B(rst_b), .BUS(adcp_if_i),
        .GO(go), .READ(read), .DEV_ADDR(dev_addr), .WR_COUNT(wr_count), .WR_DATA(wr_data),
        .BUSY(busy), .DONE(done), .NACK(nack), .RD_DATA(rd_data));
    adcp_asserts #(.FRAME_MAX(10000)) adcp_asserts_i (.REF_CLK(ref_clk), .RST_B(rst_b),
        .host_scl_out(adcp_if_i.host_scl_out), .host_scl_oe_n(adcp_if_i.host_scl_oe_n),
        .host_sda_out(adcp_if_i.host_sda_out), .host_sda_oe_n(adcp_if_i.host_sda_oe_n),
        .target_sda_out(adcp_if_i.target_sda_out),
        .target_sda_oe_n(adcp_if_i.target_sda_oe_n), .scl(adcp_if_i.scl), .sda(adcp_if_i.sda));
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    task automatic check(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // notes the expected outcome, then runs one frame to its done pulse
    task automatic frame(input string name, input logic rd, input adcp_addr_t addr,
            input logic [1:0] cnt, input logic [23:0] data);
        adcp_exp_s e;
        int n;
        e = want;
        e.sel = (addr === (ADCP_ADDR_BASE | {5'h00, addr_sel}));
        e.nack = ~e.sel;
        e.rd = rd & e.sel;
        case (want.ptr)
            ADCP_PTR_CONV: e.data = conv_data;
            ADCP_PTR_CFG: e.data = want.cfg;
            ADCP_PTR_LOW: e.data = want.low;
            default: e.data = want.high;
        endcase
        if (e.sel && !rd) begin
            e.ptr = data[17:16];
            if (cnt == 2'h3 && e.ptr == ADCP_PTR_CFG) e.cfg = data[15:0];
            if (cnt == 2'h3 && e.ptr == ADCP_PTR_LOW) e.low = data[15:0] & ~ADCP_LIMIT_RO_MASK;
            if (cnt == 2'h3 && e.ptr == ADCP_PTR_HIGH) e.high = data[15:0] | ADCP_LIMIT_RO_MASK;
        end
        want = e;
        exp_q.push_back(e);
        read = rd;
        dev_addr = addr;
        wr_count = cnt;
        wr_data = data;
        sel_seen = 1'b0;
        go = 1'b1;
        @(negedge ref_clk);
        go = 1'b0;
        check(busy === 1'b1, "busy after go");
        n = 0;
        while (done !== 1'b1 && n < 12000) begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 12000, "frame did not finish");
        @(negedge ref_clk);
        $display("test %s done", name);
    endtask
    // target selection seen during the frame
    always @(negedge ref_clk) begin
        if (selected === 1'b1) sel_seen = 1'b1;
    end
    // result side: oldest note against what the pulse of done shows
    always @(negedge ref_clk) begin
        if (done === 1'b1) begin
            check(exp_q.size() != 0, "result with no note");
            check(busy === 1'b0, "busy at done");
            if (exp_q.size() != 0) begin
                got = exp_q.pop_front();
                check(nack === got.nack, "address acknowledge");
                check(sel_seen === got.sel, "target selection");
                check(!got.rd || rd_data === got.data, "read word");
                check(cfg_reg === got.cfg, "config register");
                check(low_limit === got.low, "low limit");
                check(high_limit === got.high, "high limit");
                check(ptr === got.ptr, "pointer");
            end
        end
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_fail++;
            $display("unexpected at %0t: run too long", $time);
            end_sim();
        end
    end
    initial begin
        want = '{rd: 1'b0, nack: 1'b0, sel: 1'b0, data: 16'h0000, cfg: ADCP_CFG_RST,
            low: ADCP_LOW_RST, high: ADCP_HIGH_RST, ptr: ADCP_PTR_CONV};
        sel_seen = 1'b0;
        void'($urandom(33));
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        check(cfg_reg === ADCP_CFG_RST && low_limit === ADCP_LOW_RST &&
            high_limit === ADCP_HIGH_RST && ptr === ADCP_PTR_CONV, "reset values");
        // every strap code answers at its own address
        for (int s = 0; s < 4; s++) begin
            addr_sel = 2'(s);
            frame("strap", 1'b0, ADCP_ADDR_BASE | 7'(s), 2'h1, {6'h00, 2'(s), 16'h0000});
        end
        // full writes to every pointer; the conversion register drops its write
        for (int p = 0; p < 4; p++) begin
            frame("write", 1'b0, ADCP_ADDR_BASE | 7'(addr_sel), 2'h3,
                {6'h00, 2'(p), 16'($urandom)});
        end
        // read back without touching the pointer
        frame("persist", 1'b1, ADCP_ADDR_BASE | 7'(addr_sel), 2'h0, 24'h000000);
        frame("pointer", 1'b0, ADCP_ADDR_BASE | 7'(addr_sel), 2'h1, 24'h000000);
        conv_data = 16'($urandom);
        frame("conversion", 1'b1, ADCP_ADDR_BASE | 7'(addr_sel), 2'h0, 24'h000000);
        // another device's address is ignored
        frame("foreign", 1'b1, ADCP_ADDR_BASE | 7'(addr_sel ^ 2'h1), 2'h0, 24'h000000);
        // frame cut after the high byte moves the pointer but writes no register
        frame("partial", 1'b0, ADCP_ADDR_BASE | 7'(addr_sel), 2'h2,
            {6'h00, ADCP_PTR_CFG, 16'($urandom)});
        // config register read back through the pointer left by the cut frame
        frame("readback", 1'b1, ADCP_ADDR_BASE | 7'(addr_sel), 2'h0, 24'h000000);
        check(exp_q.size() == 0, "notes left over");
        end_sim();
    end
endmodule
